// ### fpecc_accum.sv
// Positional parity accumulator over a stream of 16-bit words
`timescale 1ns/100ps
module fpecc_accum #(
  parameter int IDX_W = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic first_i,
  input wire logic [IDX_W-1:0] idx_i,
  input wire logic [15:0] data_i,
  output logic [2*(IDX_W+4)-1:0] code_o
);
  localparam int AW = IDX_W + 4;
  logic [AW-1:0] upd_hi;
  logic [AW-1:0] upd_lo;
  logic wpar;

  // Bit address is {word index, bit index}; hi collects set address bits
  always_comb begin
    upd_hi = '0;
    upd_lo = '0;
    wpar = ^data_i;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 16; j++) begin
        if (j[k]) begin
          upd_hi[k] = upd_hi[k] ^ data_i[j];
        end else begin
          upd_lo[k] = upd_lo[k] ^ data_i[j];
        end
      end
    end
    for (int k = 0; k < IDX_W; k++) begin
      upd_hi[k+4] = wpar & idx_i[k];
      upd_lo[k+4] = wpar & ~idx_i[k];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      code_o <= '0;
    end else if (en_i) begin
      code_o <= (first_i ? '0 : code_o) ^ {upd_hi, upd_lo};
    end
  end
endmodule

// ### fpecc_defines.svh
// Constants for the flash page check-code engine
// What this block does
// - Detects two-bit errors and corrects one-bit errors in main and spare data.
// - Program streams produce 24-bit main code and 10-bit code over second, third spare words.
// - Loads recompute the code, compare with the stored code, fix a single bit.
// - Status updates after every checked load; the host may read it.
// - Status tells no error, correctable single error, uncorrectable double error.
// - Checked loads copy the stored code, not the recomputed one, to the buffer.
// - Boot loading is checked and corrected like any other load.
// - Bypass computes no codes and reports no error position.
// - Bypass programs leave the code words in the spare area untouched.
// - Bypass loads neither recompute nor correct; status invalid, stored code still copied.
// - Bit nine of configuration register one selects bypass; keep checking enabled.
// - Host maps out invalid blocks; block zero is always valid.
`ifndef FPECC_DEFINES_SVH
`define FPECC_DEFINES_SVH
`define FPECC_MAIN_WORDS 9'h100
`define FPECC_SECT_LAST 9'h107
`define FPECC_SPARE_CHK0 9'h101
`define FPECC_SPARE_CHK1 9'h102
`define FPECC_CODE_W0 9'h105
`define FPECC_CODE_W1 9'h106
`define FPECC_CODE_W2 9'h107
`define FPECC_BYPASS_BIT 9
`define FPECC_SECTORS 4
`define FPECC_MAIN_PAIRS 12'hfff
`define FPECC_SPARE_PAIRS 12'h01f
`endif

// ### fpecc_engine.sv
// Check-code generation, checking and single-bit correction for sector streams
`timescale 1ns/100ps
`include "fpecc_defines.svh"
module fpecc_engine
  import fpecc_pkg::*;
#(
  parameter int SECTORS = `FPECC_SECTORS
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [15:0] sys_cfg1_i,
  input wire logic start_i,
  input wire logic load_i,
  input wire logic boot_i,
  input wire logic in_valid_i,
  input wire logic [15:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [15:0] out_data_o,
  output logic [8:0] out_addr_o,
  output logic [1:0] out_sector_o,
  output logic fix_valid_o,
  output logic [8:0] fix_addr_o,
  output logic [1:0] fix_sector_o,
  output logic [15:0] fix_flip_o,
  output logic busy_o,
  output logic done_o,
  output logic st_valid_o,
  output logic [1:0] st_main_o,
  output logic [1:0] st_spare_o,
  output logic [11:0] pos_main_o,
  output logic [4:0] pos_spare_o
);
  fpecc_state_t state;
  logic load_mode;
  logic bypass;
  logic [8:0] wcnt;
  logic [1:0] sect;
  logic [23:0] code_m;
  logic [9:0] code_s;
  logic [23:0] stored_m;
  logic [9:0] stored_s;
  logic fix_m_pend;
  logic fix_s_pend;
  logic take;
  logic last_word;
  logic [2:0] cls_m;
  logic [2:0] cls_s;

  // Returns {data bit to fix, error class} from a syndrome {hi, lo}
  function automatic logic [2:0] classify(input logic [23:0] syn, input logic [11:0] pairs);
    logic all_pairs;
    logic [4:0] ones;
    all_pairs = 1'b1;
    ones = '0;
    for (int k = 0; k < 12; k++) begin
      if (pairs[k] && !(syn[k+12] ^ syn[k])) begin
        all_pairs = 1'b0;
      end
      ones = ones + 5'(syn[k+12]) + 5'(syn[k]);
    end
    if (syn == 24'h0) begin
      classify = {1'b0, FPECC_ERR_NONE};
    end else if (all_pairs) begin
      classify = {1'b1, FPECC_ERR_CORR};
    end else if (ones == 5'h1) begin
      classify = {1'b0, FPECC_ERR_CORR};
    end else begin
      classify = {1'b0, FPECC_ERR_UNCORR};
    end
  endfunction

  assign take = (state == FPECC_STREAM) && in_valid_i;
  assign last_word = (wcnt == `FPECC_SECT_LAST);
  assign in_ready_o = (state == FPECC_STREAM);
  assign busy_o = (state != FPECC_IDLE);
  assign cls_m = classify(stored_m ^ code_m, `FPECC_MAIN_PAIRS);
  assign cls_s = classify({7'h0, stored_s[9:5], 7'h0, stored_s[4:0]} ^
                          {7'h0, code_s[9:5], 7'h0, code_s[4:0]}, `FPECC_SPARE_PAIRS);

  // Background generation, held off in bypass
  fpecc_accum #(.IDX_W(8)) u_main (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .en_i(take && !bypass && wcnt < `FPECC_MAIN_WORDS),
    .first_i(wcnt == 9'h0),
    .idx_i(wcnt[7:0]),
    .data_i(in_data_i),
    .code_o(code_m)
  );
  fpecc_accum #(.IDX_W(1)) u_spare (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .en_i(take && !bypass && (wcnt == `FPECC_SPARE_CHK0 || wcnt == `FPECC_SPARE_CHK1)),
    .first_i(wcnt == `FPECC_SPARE_CHK0),
    .idx_i(wcnt == `FPECC_SPARE_CHK1),
    .data_i(in_data_i),
    .code_o(code_s)
  );

  // Operation sequencing
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state <= FPECC_IDLE;
      load_mode <= 1'b0;
      bypass <= 1'b0;
      wcnt <= 9'h0;
      sect <= 2'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        FPECC_IDLE: begin
          if (start_i) begin
            state <= FPECC_STREAM;
            // Boot reads block zero, always valid, through the same checked path
            load_mode <= load_i | boot_i;
            bypass <= sys_cfg1_i[`FPECC_BYPASS_BIT];
            wcnt <= 9'h0;
            sect <= 2'h0;
          end
        end
        FPECC_STREAM: begin
          if (take) begin
            wcnt <= last_word ? 9'h0 : wcnt + 9'h1;
            if (last_word && load_mode && !bypass) begin
              state <= FPECC_CHECK;
            end else if (last_word) begin
              sect <= sect + 2'h1;
              if (sect == 2'(SECTORS - 1)) begin
                state <= FPECC_IDLE;
                done_o <= 1'b1;
              end
            end
          end
        end
        FPECC_CHECK, FPECC_FIX: begin
          if ((state == FPECC_CHECK && !cls_m[2] && !cls_s[2]) ||
              (state == FPECC_FIX && !(fix_m_pend && fix_s_pend))) begin
            sect <= sect + 2'h1;
            if (sect == 2'(SECTORS - 1)) begin
              state <= FPECC_IDLE;
              done_o <= 1'b1;
            end else begin
              state <= FPECC_STREAM;
            end
          end else if (state == FPECC_CHECK) begin
            state <= FPECC_FIX;
          end
        end
      endcase
    end
  end

  // Output stream; code words replaced only on checked programs
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= 16'h0;
      out_addr_o <= 9'h0;
      out_sector_o <= 2'h0;
    end else begin
      out_valid_o <= take;
      if (take) begin
        out_addr_o <= wcnt;
        out_sector_o <= sect;
        out_data_o <= in_data_i;
        if (!load_mode && !bypass) begin
          if (wcnt == `FPECC_CODE_W0) begin
            out_data_o <= code_m[15:0];
          end else if (wcnt == `FPECC_CODE_W1) begin
            out_data_o <= {code_s[7:0], code_m[23:16]};
          end else if (wcnt == `FPECC_CODE_W2) begin
            out_data_o <= {in_data_i[15:2], code_s[9:8]};
          end
        end
      end
    end
  end

  // Stored code captured from the spare area during loads
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      stored_m <= 24'h0;
      stored_s <= 10'h0;
    end else if (take && load_mode) begin
      if (wcnt == `FPECC_CODE_W0) begin
        stored_m[15:0] <= in_data_i;
      end else if (wcnt == `FPECC_CODE_W1) begin
        stored_m[23:16] <= in_data_i[7:0];
        stored_s[7:0] <= in_data_i[15:8];
      end else if (wcnt == `FPECC_CODE_W2) begin
        stored_s[9:8] <= in_data_i[1:0];
      end
    end
  end

  // Status after every checked load; bypass marks it invalid
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_valid_o <= 1'b0;
      st_main_o <= FPECC_ERR_NONE;
      st_spare_o <= FPECC_ERR_NONE;
      pos_main_o <= 12'h0;
      pos_spare_o <= 5'h0;
    end else if (state == FPECC_IDLE && start_i && sys_cfg1_i[`FPECC_BYPASS_BIT]) begin
      st_valid_o <= 1'b0;
      pos_main_o <= 12'h0;
      pos_spare_o <= 5'h0;
    end else if (state == FPECC_CHECK) begin
      st_valid_o <= 1'b1;
      st_main_o <= cls_m[1:0];
      st_spare_o <= cls_s[1:0];
      pos_main_o <= cls_m[2] ? code_m[23:12] ^ stored_m[23:12] : 12'h0;
      pos_spare_o <= cls_s[2] ? code_s[9:5] ^ stored_s[9:5] : 5'h0;
    end
  end

  // Single-bit repair written back into the host data buffer
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      fix_m_pend <= 1'b0;
      fix_s_pend <= 1'b0;
      fix_valid_o <= 1'b0;
      fix_addr_o <= 9'h0;
      fix_sector_o <= 2'h0;
      fix_flip_o <= 16'h0;
    end else begin
      fix_valid_o <= 1'b0;
      if (state == FPECC_CHECK) begin
        fix_m_pend <= cls_m[2];
        fix_s_pend <= cls_s[2];
      end else if (state == FPECC_FIX && fix_m_pend) begin
        fix_m_pend <= 1'b0;
        fix_valid_o <= 1'b1;
        fix_sector_o <= sect;
        fix_addr_o <= {1'b0, pos_main_o[11:4]};
        fix_flip_o <= 16'h1 << pos_main_o[3:0];
      end else if (state == FPECC_FIX && fix_s_pend) begin
        fix_s_pend <= 1'b0;
        fix_valid_o <= 1'b1;
        fix_sector_o <= sect;
        fix_addr_o <= `FPECC_SPARE_CHK0 + {8'h0, pos_spare_o[4]};
        fix_flip_o <= 16'h1 << pos_spare_o[3:0];
      end
    end
  end

  chk_bypass_nofix: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    bypass && state != FPECC_IDLE |-> !fix_valid_o && state != FPECC_CHECK)
    else $error("fix or check during bypass");
  chk_bypass_nopos: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    state == FPECC_IDLE && start_i && sys_cfg1_i[`FPECC_BYPASS_BIT]
    |=> !st_valid_o && pos_main_o == 12'h0 && pos_spare_o == 5'h0)
    else $error("bypass left position or valid status");
  chk_prog_code: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    take && !load_mode && !bypass && wcnt == `FPECC_CODE_W0 |=> out_data_o == code_m[15:0])
    else $error("program code word wrong");
  chk_bypass_keep: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    take && bypass && wcnt >= `FPECC_CODE_W0 |=> out_data_o == $past(in_data_i))
    else $error("bypass program altered code word");
  chk_load_copy: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    take && load_mode && wcnt >= `FPECC_CODE_W0 |=> out_data_o == $past(in_data_i))
    else $error("load copied a recomputed code");
  chk_status_after: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    take && load_mode && !bypass && last_word |-> ##2 st_valid_o)
    else $error("status not updated after load");
  chk_fix_onehot: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    fix_valid_o |-> $onehot(fix_flip_o) && $past(state) == FPECC_FIX)
    else $error("fix not a single bit");
  chk_class_legal: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    st_valid_o |-> st_main_o != 2'h3 && st_spare_o != 2'h3)
    else $error("illegal error class");
  chk_uncorr_nofix: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    state == FPECC_CHECK && cls_m[1:0] == FPECC_ERR_UNCORR |=> !fix_m_pend)
    else $error("uncorrectable main error scheduled a fix");
  cov_prog_done: cover property (@(posedge mclk_i) done_o && !load_mode);
  cov_load_fix: cover property (@(posedge mclk_i) fix_valid_o);
  cov_uncorr: cover property (@(posedge mclk_i) st_valid_o && st_main_o == FPECC_ERR_UNCORR);
  cov_bypass_load: cover property (@(posedge mclk_i) done_o && load_mode && bypass);
endmodule

// ### fpecc_engine_tb.sv
// Self-checking bench for the flash page check-code engine
`timescale 1ns/100ps
module fpecc_engine_tb;
  import fpecc_pkg::*;
  localparam int NS = 4;
  localparam int WPS = 264;
  logic mclk_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, load_i = 1'b0, boot_i = 1'b0;
  logic gap = 1'b0;
  logic in_valid_i, in_ready_o, out_valid_o, fix_valid_o, busy_o, done_o, st_valid_o;
  logic [15:0] sys_cfg1_i = 16'h0000, in_data_i, out_data_o, fix_flip_o;
  logic [8:0] out_addr_o, fix_addr_o;
  logic [1:0] out_sector_o, fix_sector_o, st_main_o, st_spare_o;
  logic [11:0] pos_main_o;
  logic [4:0] pos_spare_o;
  int num_errors = 0, samples_checked = 0, n_out = 0, wait_st = 0, st_sec = 0, s, w;
  logic [31:0] seed = 32'h6d69;
  logic [15:0] page [NS*WPS];
  logic [15:0] sent [NS*WPS];
  logic prog = 1'b1, byp = 1'b0;
  logic [1:0] e_main [NS];
  logic [1:0] e_spare [NS];
  logic [11:0] e_pm [NS];
  logic [4:0] e_ps [NS];
  logic [26:0] fix_exp [$];
  logic [26:0] fix_got [$];
  logic [23:0] cm;
  logic [23:0] cs;
  logic [9:0] sc;
  logic [15:0] ew;

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  fpecc_engine #(.SECTORS(NS)) dut_u (.mclk_i, .resetn_i, .sys_cfg1_i, .start_i, .load_i,
    .boot_i, .in_valid_i, .in_data_i, .in_ready_o, .out_valid_o, .out_data_o, .out_addr_o,
    .out_sector_o, .fix_valid_o, .fix_addr_o, .fix_sector_o, .fix_flip_o, .busy_o, .done_o,
    .st_valid_o, .st_main_o, .st_spare_o, .pos_main_o, .pos_spare_o);
  fpecc_partner partner_u (.mclk_i, .resetn_i, .gap_i(gap), .in_ready_i(in_ready_o),
    .in_valid_o(in_valid_i), .in_data_o(in_data_i));

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask

  task report_and_stop;
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Reference positional parity: {hi, lo} over bit address word*16+bit
  function automatic logic [23:0] ref_code(input int base, input int nw, input int aw);
    logic [11:0] hi;
    logic [11:0] lo;
    int a;
    hi = '0;
    lo = '0;
    for (int i = 0; i < nw; i++) begin
      for (int j = 0; j < 16; j++) begin
        if (sent[base + i][j]) begin
          a = i * 16 + j;
          for (int k = 0; k < aw; k++) begin
            if (a[k]) hi[k] = ~hi[k];
            else lo[k] = ~lo[k];
          end
        end
      end
    end
    return {hi, lo};
  endfunction

  task rnd(output logic [15:0] r);
    seed = lfsr_step(seed);
    r = seed[15:0];
  endtask

  // Output stream, fix pulses and per-sector status
  always @(posedge mclk_i) begin
    if (resetn_i) begin
      if (out_valid_o) begin
        s = n_out / WPS;
        w = n_out % WPS;
        check(out_sector_o === 2'(s) && out_addr_o === 9'(w), "word position");
        if (prog && !byp && w >= 261) begin
          cm = ref_code(s * WPS, 256, 12);
          cs = ref_code(s * WPS + 257, 2, 5);
          sc = {cs[16:12], cs[4:0]};
          ew = (w == 261) ? cm[15:0] : (w == 262) ? {sc[7:0], cm[23:16]} :
            {sent[n_out][15:2], sc[9:8]};
          check(out_data_o === ew, "code word");
        end else check(out_data_o === sent[n_out], "passed word");
        if (prog) page[n_out] = out_data_o;
        n_out++;
      end
      if (fix_valid_o) fix_got.push_back({fix_sector_o, fix_addr_o, fix_flip_o});
      if (wait_st == 1) begin
        if (byp) check(st_valid_o === 1'b0 && pos_main_o === 12'h000 &&
          pos_spare_o === 5'h00, "bypass status");
        else check(st_valid_o === 1'b1 && st_main_o === e_main[st_sec] &&
          st_spare_o === e_spare[st_sec] && pos_spare_o === e_ps[st_sec] &&
          (e_main[st_sec] == 2'h2 || pos_main_o === e_pm[st_sec]), "load status");
      end
      if (out_valid_o && out_addr_o == 9'h107 && !prog) begin
        wait_st = 2;
        st_sec = out_sector_o;
      end else if (wait_st > 0) wait_st--;
    end
  end

  task automatic run_op(input logic ld, bt, bp);
    logic [15:0] r;
    int i;
    n_out = 0;
    prog = !ld;
    byp = bp;
    fix_got.delete();
    rnd(r);
    @(posedge mclk_i);
    start_i <= 1'b1;
    load_i <= ld;
    boot_i <= bt;
    gap <= r[0];
    sys_cfg1_i <= {r[15:10], bp, r[8:0]};
    @(posedge mclk_i);
    start_i <= 1'b0;
    repeat (19) @(posedge mclk_i);
    @(negedge mclk_i);
    check(busy_o === 1'b1, "busy during page");
    @(posedge mclk_i);
    // Refused while busy
    start_i <= 1'b1;
    load_i <= !ld;
    sys_cfg1_i[9] <= !bp;
    @(posedge mclk_i);
    start_i <= 1'b0;
    for (i = 0; i < 30000 && done_o !== 1'b1; i++) @(negedge mclk_i);
    if (i == 30000) begin
      check(1'b0, "no end of page");
      report_and_stop();
    end
    repeat (4) @(negedge mclk_i);
    check(busy_o === 1'b0, "busy after page");
    check(n_out == NS * WPS, "word count");
    check(fix_got.size() == fix_exp.size(), "fix count");
    foreach (fix_exp[k]) if (k < fix_got.size()) check(fix_got[k] === fix_exp[k], "fix");
  endtask

  task automatic prog_page(input logic bp);
    fix_exp.delete();
    for (int n = 0; n < NS * WPS; n++) begin
      rnd(sent[n]);
      // Block stays marked valid
      if (n == 256) sent[n] = 16'hffff;
      partner_u.fifo.push_back(sent[n]);
    end
    run_op(1'b0, 1'b0, bp);
  endtask

  // Sector k: 0 clean, 1 one main and one spare flip, 2 two main flips
  // Marker word never altered; reported load errors are expected
  task automatic load_page(input logic bt, bp, input int kk);
    logic [15:0] r;
    int k;
    fix_exp.delete();
    sent = page;
    for (int sc = 0; sc < NS; sc++) begin
      k = (sc + kk) % 3;
      rnd(r);
      e_main[sc] = 2'(k);
      e_spare[sc] = (k == 1) ? 2'h1 : 2'h0;
      e_pm[sc] = (k == 1) ? {r[7:0], r[11:8]} : 12'h000;
      e_ps[sc] = (k == 1) ? {r[8], r[15:12]} : 5'h00;
      if (k > 0) sent[sc * WPS + r[7:0]][r[11:8]] ^= 1'b1;
      if (k == 2) sent[sc * WPS + (r[7:0] ^ 8'h01)][r[11:8]] ^= 1'b1;
      if (k == 1) sent[sc * WPS + 257 + r[8]][r[15:12]] ^= 1'b1;
      if (k == 1 && !bp) begin
        fix_exp.push_back({2'(sc), 1'b0, r[7:0], 16'h0001 << r[11:8]});
        fix_exp.push_back({2'(sc), 9'h101 + 9'(r[8]), 16'h0001 << r[15:12]});
      end
    end
    foreach (sent[n]) partner_u.fifo.push_back(sent[n]);
    run_op(1'b1, bt, bp);
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    prog_page(1'b0);
    load_page(1'b0, 1'b0, 0);
    load_page(1'b1, 1'b0, 1);
    prog_page(1'b1);
    load_page(1'b0, 1'b1, 1);
    prog_page(1'b0);
    load_page(1'b0, 1'b0, 2);
    report_and_stop();
  end
endmodule

// ### fpecc_partner.sv
// Host-side word source that feeds sector streams into the engine
`timescale 1ns/100ps
module fpecc_partner (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic gap_i,
  input wire logic in_ready_i,
  output logic in_valid_o = 1'b0,
  output logic [15:0] in_data_o = 16'h0000
);
  logic [15:0] fifo [$];
  logic taken;
  // Status is never polled here; the engine corrects on its own
  // No program failure is reported, so no block is ever replaced
  always @(posedge mclk_i) begin
    taken = in_valid_o && in_ready_i;
    if (taken) void'(fifo.pop_front());
    if (resetn_i && fifo.size() > 0 && !(taken && gap_i)) begin
      in_valid_o <= 1'b1;
      in_data_o <= fifo[0];
    end else begin
      // Released data line keeps changing
      in_valid_o <= 1'b0;
      in_data_o <= ~in_data_o;
    end
  end
endmodule

// ### fpecc_pkg.sv
// Types for the flash page check-code engine
package fpecc_pkg;
  typedef enum logic [3:0] {
    FPECC_IDLE = 4'h1,
    FPECC_STREAM = 4'h2,
    FPECC_CHECK = 4'h4,
    FPECC_FIX = 4'h8
  } fpecc_state_t;
  typedef enum logic [1:0] {
    FPECC_ERR_NONE = 2'h0,
    FPECC_ERR_CORR = 2'h1,
    FPECC_ERR_UNCORR = 2'h2
  } fpecc_err_t;
endpackage
